// ==== core/aebm_defs.svh ====
// aebm_defs.svh: constants of the asynchronous external bus master
// assumes: included by bare name from the package and the design files
`ifndef AEBM_DEFS_SVH
`define AEBM_DEFS_SVH
// transfer size pin codes {hi,lo}
`define AEBM_SIZ_BYTE    2'h1
`define AEBM_SIZ_WORD    2'h2
`define AEBM_SIZ_3BYTE   2'h3
`define AEBM_SIZ_LONG    2'h0
// remaining byte counts
`define AEBM_CNT_ZERO    3'h0
`define AEBM_CNT_BYTE    3'h1
`define AEBM_CNT_WORD    3'h2
`define AEBM_CNT_3BYTE   3'h3
`define AEBM_CNT_LONG    3'h4
// space code low bits, top bit always set
`define AEBM_SP_RSVD     2'h0
`define AEBM_SP_DATA     2'h1
`define AEBM_SP_PROG     2'h2
`define AEBM_SP_CPU      2'h3
`define AEBM_FC_TOP      1'h1
// direction pin
`define AEBM_RW_READ     1'h1
`define AEBM_RW_WRITE    1'h0
// widths
`define AEBM_ADDR_W      20
`define AEBM_PIN_ADDR_W  24
`define AEBM_HI_LINES    4
`define AEBM_DATA_W      16
`define AEBM_OPD_W       32
`define AEBM_BYTE_W      8
`define AEBM_CTL_W       6
`define AEBM_CTL_RST     6'h1F
`define AEBM_FIFO_DEPTH  16
`endif

// ==== core/aebm_pkg.sv ====
// aebm_pkg: types and size arithmetic of the external bus master
// assumes: aebm_defs.svh on the include path
`include "aebm_defs.svh"
package aebm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AS   = 3'b010,
      ST_DATA = 3'b011,
      ST_WAIT = 3'b100,
      ST_END  = 3'b101
   } aebm_state_e;

   function automatic logic [2:0] aebm_siz_cnt(input logic [1:0] siz);
      logic [2:0] c;
      c = `AEBM_CNT_LONG;
      unique case (siz)
         `AEBM_SIZ_BYTE:  c = `AEBM_CNT_BYTE;
         `AEBM_SIZ_WORD:  c = `AEBM_CNT_WORD;
         `AEBM_SIZ_3BYTE: c = `AEBM_CNT_3BYTE;
         `AEBM_SIZ_LONG:  c = `AEBM_CNT_LONG;
      endcase
      return c;
   endfunction

   function automatic logic [1:0] aebm_cnt_siz(input logic [2:0] cnt);
      logic [1:0] s;
      s = `AEBM_SIZ_LONG;
      case (cnt)
         `AEBM_CNT_BYTE:  s = `AEBM_SIZ_BYTE;
         `AEBM_CNT_WORD:  s = `AEBM_SIZ_WORD;
         `AEBM_CNT_3BYTE: s = `AEBM_SIZ_3BYTE;
         default:         s = `AEBM_SIZ_LONG;
      endcase
      return s;
   endfunction

   // bytes one cycle moves: an aligned word at most
   function automatic logic [2:0] aebm_moved(input logic [2:0] cnt,
                                             input logic       a0,
                                             input logic       wide);
      if (!wide || a0 || cnt == `AEBM_CNT_BYTE)
         return `AEBM_CNT_BYTE;
      return `AEBM_CNT_WORD;
   endfunction
endpackage

// ==== core/aebm_sync.sv ====
// aebm_sync: two-flop synchroniser for pin inputs
// assumes: inputs asynchronous to i_mclk, levels only
module aebm_sync
   import aebm_pkg::*;
#(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : g_chk
      $error("aebm_sync: WIDTH must be at least 1");
   end

   // first stage is read by the second stage only
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// ==== core/aebm_fifo.sv ====
// aebm_fifo: request queue in front of the bus engine
// assumes: one clock, synchronous active-high reset
`include "aebm_defs.svh"
module aebm_fifo
   import aebm_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = `AEBM_FIFO_DEPTH
) (
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             full;
   logic             empty;

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("aebm_fifo: DEPTH must be a power of two, WIDTH >= 1");
   end

   // extra pointer bit tells full from empty
   assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge i_mclk) begin
      if (i_in_valid && !full) begin
         mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wr_ptr_r <= '0;
      end else if (i_in_valid && !full) begin
         wr_ptr_r <= wr_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rd_ptr_r <= '0;
      end else if (i_out_ready && !empty) begin
         rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule

// ==== core/aebm_master.sv ====
// aebm_master: asynchronous external bus master, internal side to pins
// assumes: one half bus clock per i_mclk cycle; pins sampled via sync
//
// Behaviour
// RULE1 - full mode 16 data lines, partial 8
// RULE2 - top four address lines copy bit 19
// RULE3 - partial mode: 8-bit ports, split transfers
// RULE4 - address, size, space, direction driven together
// RULE5 - size pins give bytes still remaining
// RULE6 - cycle outputs valid while address strobe low
// RULE7 - direction changes only at cycle start
// RULE8 - space code top bit one, 5/6/7
// RULE9 - address of most significant byte
// RULE10 - address strobe half clock after start
// RULE11 - read data captured at cycle end
// RULE12 - writes drive all 16 data lines
// RULE13 - write data half clock after strobe
// RULE14 - read data strobe with address strobe
// RULE15 - write data strobe one clock later
// RULE16 - slave acknowledges end cycle, give width
// RULE17 - cycle stretched until slave terminates
// RULE18 - bus fault terminates cycle as error
// RULE19 - fault with halt gives bus error exception
// RULE20 - auto-vector ends interrupt acknowledge cycle
// RULE21 - auto-vector ignored outside interrupt acknowledge
// RULE22 - acknowledge pair decode, both low reserved
// RULE23 - 8-bit slave sits on upper lines
// RULE24 - long word: upper word first
// RULE25 - outputs held until acknowledge or fault
`include "aebm_defs.svh"
module aebm_master
   import aebm_pkg::*;
#(
   parameter int FIFO_DEPTH = `AEBM_FIFO_DEPTH
) (
   input  wire logic                         i_mclk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_full_mode,
   input  wire logic                         i_req_valid,
   output logic                              o_req_ready,
   input  wire logic [`AEBM_ADDR_W-1:0]      i_req_addr,
   input  wire logic                         i_req_write,
   input  wire logic [1:0]                   i_req_siz,
   input  wire logic [1:0]                   i_req_space,
   input  wire logic                         i_req_iack,
   input  wire logic [`AEBM_OPD_W-1:0]       i_req_wdata,
   output logic                              o_rsp_valid,
   output logic      [`AEBM_OPD_W-1:0]       o_rsp_rdata,
   output logic                              o_rsp_fault,
   output logic                              o_rsp_auto_vector_ack,
   output logic                              o_bus_err_exc,
   output logic      [`AEBM_PIN_ADDR_W-1:0]  o_addr,
   output logic                              o_xfer_size_hi,
   output logic                              o_xfer_size_lo,
   output logic      [2:0]                   o_space_code,
   output logic                              o_rd_wr,
   output logic                              o_address_strobe_n,
   output logic                              o_data_strobe_n,
   input  wire logic [`AEBM_DATA_W-1:0]      i_data,
   output logic      [`AEBM_DATA_W-1:0]      o_data,
   output logic                              o_data_oe,
   input  wire logic                         i_ack_width_hi_n,
   input  wire logic                         i_ack_width_lo_n,
   input  wire logic                         i_bus_fault_n,
   input  wire logic                         i_halt_n,
   input  wire logic                         i_auto_vector_ack_n
);
   localparam int REQ_W = `AEBM_ADDR_W + 6 + `AEBM_OPD_W;
   localparam int BW    = `AEBM_BYTE_W;

   if (FIFO_DEPTH < 2) begin : g_chk
      $error("aebm_master: FIFO_DEPTH must be at least 2");
   end

   aebm_state_e                st_r;
   aebm_state_e                st_nxt;
   logic [REQ_W-1:0]           fifo_in;
   logic [REQ_W-1:0]           fifo_out;
   logic                       fifo_valid;
   logic                       fifo_take;
   logic [`AEBM_ADDR_W-1:0]    q_addr;
   logic                       q_write;
   logic [1:0]                 q_siz;
   logic [1:0]                 q_space;
   logic                       q_iack;
   logic [`AEBM_OPD_W-1:0]     q_wdata;
   logic [`AEBM_CTL_W-1:0]     ctl_s;
   logic [`AEBM_DATA_W-1:0]    din_s;
   logic                       full_s;
   logic                       ack_hi;
   logic                       ack_lo;
   logic                       fault;
   logic                       halt;
   logic                       auto_vector_ack;
   logic                       ack_end;
   logic                       auto_vector_ack_end;
   logic                       term;
   logic                       wide;
   logic [2:0]                 moved;
   logic [`AEBM_ADDR_W-1:0]    addr_r;
   logic [2:0]                 cnt_r;
   logic                       write_r;
   logic [1:0]                 space_r;
   logic                       iack_r;
   logic [`AEBM_OPD_W-1:0]     opd_r;
   logic                       fault_r;
   logic                       auto_vector_ack_r;
   logic [`AEBM_ADDR_W-1:0]    cyc_addr;
   logic [2:0]                 cyc_cnt;
   logic                       cyc_write;
   logic [1:0]                 cyc_space;
   logic                       cyc_iack;
   logic [1:0]                 sp_low;
   logic [1:0]                 siz_pins;
   logic [`AEBM_ADDR_W-1:0]    pin_addr_r;
   logic                       strobe_on;

   // request path: queue holds requests while the bus is busy, stalls the source only when full
   assign fifo_in = {i_req_addr, i_req_write, i_req_siz, i_req_space,
                     i_req_iack, i_req_wdata};
   assign {q_addr, q_write, q_siz, q_space, q_iack, q_wdata} = fifo_out;
   assign fifo_take = (st_r == ST_IDLE);

   aebm_fifo #(
      .WIDTH (REQ_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (i_req_valid),
      .o_in_ready  (o_req_ready),
      .i_in_data   (fifo_in),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_take),
      .o_out_data  (fifo_out)
   );

   // pins cross two flops; adds two cycles to every termination
   aebm_sync #(
      .WIDTH   (`AEBM_CTL_W),
      .RST_VAL (`AEBM_CTL_RST)
   ) u_sync_ctl (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_full_mode, i_ack_width_hi_n, i_ack_width_lo_n,
                   i_bus_fault_n, i_halt_n, i_auto_vector_ack_n}),
      .o_sync    (ctl_s)
   );

   aebm_sync #(
      .WIDTH   (`AEBM_DATA_W),
      .RST_VAL ('0)
   ) u_sync_data (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_data),
      .o_sync    (din_s)
   );

   assign full_s = ctl_s[5];
   assign ack_hi = !ctl_s[4];
   assign ack_lo = !ctl_s[3];
   assign fault  = !ctl_s[2];
   assign halt   = !ctl_s[1];
   assign auto_vector_ack   = !ctl_s[0];

   // one acknowledge alone ends the cycle; both is reserved, keeps waiting
   assign ack_end  = ack_hi ^ ack_lo; // RULE22 RULE16
   // 16-bit answer only counts with all data lines present
   assign wide     = ack_hi && !ack_lo && full_s; // RULE1 RULE3 RULE23
   assign auto_vector_ack_end = iack_r && auto_vector_ack; // RULE20 RULE21
   assign term     = (st_r == ST_WAIT) && (ack_end || auto_vector_ack_end || fault);
   assign moved    = aebm_moved(cnt_r, addr_r[0], wide);

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: if (fifo_valid) st_nxt = ST_ADDR;
         ST_ADDR: st_nxt = ST_AS;
         ST_AS:   st_nxt = ST_DATA;
         ST_DATA: st_nxt = ST_WAIT;
         ST_WAIT: if (term) st_nxt = ST_END; // RULE17 RULE25
         ST_END:  st_nxt = (cnt_r == `AEBM_CNT_ZERO) ? ST_IDLE : ST_ADDR;
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // values of the cycle about to start
   assign cyc_addr  = (st_r == ST_IDLE) ? q_addr : addr_r;
   assign cyc_cnt   = (st_r == ST_IDLE) ? aebm_siz_cnt(q_siz) : cnt_r;
   assign cyc_write = (st_r == ST_IDLE) ? q_write : write_r;
   assign cyc_space = (st_r == ST_IDLE) ? q_space : space_r;
   assign cyc_iack  = (st_r == ST_IDLE) ? q_iack : iack_r;
   // reserved space 4 is never put out
   assign sp_low    = cyc_iack ? `AEBM_SP_CPU :
                      (cyc_space == `AEBM_SP_RSVD) ? `AEBM_SP_DATA :
                      cyc_space; // RULE8
   assign siz_pins  = aebm_cnt_siz(cyc_cnt); // RULE5

   // operand bookkeeping across split cycles
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         addr_r  <= '0;
         cnt_r   <= `AEBM_CNT_ZERO;
         write_r <= 1'b0;
         space_r <= `AEBM_SP_DATA;
         iack_r  <= 1'b0;
         opd_r   <= '0;
         fault_r <= 1'b0;
         auto_vector_ack_r  <= 1'b0;
      end else if (st_r == ST_IDLE && fifo_valid) begin
         addr_r  <= q_addr;
         cnt_r   <= aebm_siz_cnt(q_siz);
         write_r <= q_write;
         space_r <= q_space;
         iack_r  <= q_iack;
         // left-justify so the top byte is always the next one out
         opd_r   <= q_write ? q_wdata << {`AEBM_CNT_LONG -
                    aebm_siz_cnt(q_siz), 3'h0} : '0;
         fault_r <= 1'b0;
         auto_vector_ack_r  <= 1'b0;
      end else if (term) begin
         if (fault) begin
            cnt_r   <= `AEBM_CNT_ZERO; // RULE18
            fault_r <= 1'b1;
         end else if (auto_vector_ack_end) begin
            cnt_r  <= `AEBM_CNT_ZERO;
            auto_vector_ack_r <= 1'b1;
         end else begin
            // upper word goes first, then the address advances
            cnt_r  <= cnt_r - moved; // RULE3 RULE24
            addr_r <= addr_r + {{(`AEBM_ADDR_W-3){1'b0}}, moved};
            if (write_r) begin
               opd_r <= opd_r << {moved, 3'h0};
            end else if (moved == `AEBM_CNT_WORD) begin
               opd_r <= {opd_r[`AEBM_OPD_W-2*BW-1:0], din_s}; // RULE11
            end else if (wide && addr_r[0]) begin
               // odd byte of a wide port comes on the lower lines
               opd_r <= {opd_r[`AEBM_OPD_W-BW-1:0], din_s[BW-1:0]};
            end else begin
               opd_r <= {opd_r[`AEBM_OPD_W-BW-1:0],
                         din_s[`AEBM_DATA_W-1:BW]}; // RULE23
            end
         end
      end
   end

   // cycle outputs change only when a cycle starts
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pin_addr_r     <= '0;
         o_xfer_size_hi <= 1'b0;
         o_xfer_size_lo <= 1'b1;
         o_space_code   <= {`AEBM_FC_TOP, `AEBM_SP_DATA};
         o_rd_wr        <= `AEBM_RW_READ;
      end else if (st_nxt == ST_ADDR) begin
         pin_addr_r     <= cyc_addr; // RULE4 RULE9
         o_xfer_size_hi <= siz_pins[1];
         o_xfer_size_lo <= siz_pins[0];
         o_space_code   <= {`AEBM_FC_TOP, sp_low};
         // held between cycles, so back-to-back writes keep it low
         o_rd_wr        <= cyc_write ? `AEBM_RW_WRITE : `AEBM_RW_READ; // RULE7
      end
   end

   assign o_addr = {{`AEBM_HI_LINES{pin_addr_r[`AEBM_ADDR_W-1]}},
                    pin_addr_r}; // RULE2

   assign strobe_on = (st_nxt == ST_AS) || (st_nxt == ST_DATA) ||
                      (st_nxt == ST_WAIT);

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_address_strobe_n <= 1'b1;
         o_data_strobe_n    <= 1'b1;
      end else begin
         o_address_strobe_n <= !strobe_on; // RULE10 RULE6
         o_data_strobe_n    <= !((strobe_on && !write_r) ||
                                 (st_nxt == ST_WAIT && write_r)); // RULE14 RULE15
      end
   end

   // write data: both lanes, byte duplicated on odd address
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_data    <= '0;
         o_data_oe <= 1'b0;
      end else begin
         if (st_nxt == ST_DATA) begin
            o_data <= addr_r[0] ?
               {2{opd_r[`AEBM_OPD_W-1 -: BW]}} :
               opd_r[`AEBM_OPD_W-1 -: `AEBM_DATA_W]; // RULE12
         end
         o_data_oe <= write_r && (st_nxt == ST_DATA ||
                                  st_nxt == ST_WAIT); // RULE13
      end
   end

   // answers to the internal side: valid and bus error are one-cycle pulses, data and flags held
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_rsp_valid   <= 1'b0;
         o_rsp_rdata   <= '0;
         o_rsp_fault   <= 1'b0;
         o_rsp_auto_vector_ack    <= 1'b0;
         o_bus_err_exc <= 1'b0;
      end else begin
         o_rsp_valid   <= (st_r == ST_END) && (cnt_r == `AEBM_CNT_ZERO);
         if (st_r == ST_END && cnt_r == `AEBM_CNT_ZERO) begin
            o_rsp_rdata <= write_r ? '0 : opd_r;
            o_rsp_fault <= fault_r;
            o_rsp_auto_vector_ack  <= auto_vector_ack_r;
         end
         o_bus_err_exc <= term && fault && halt; // RULE19
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   property p_addr_repl;
      o_addr[`AEBM_PIN_ADDR_W-1 -: `AEBM_HI_LINES] ==
         {`AEBM_HI_LINES{o_addr[`AEBM_ADDR_W-1]}};
   endproperty
   a_addr_repl: assert property (p_addr_repl) // RULE2
      else $error("upper address lines differ from bit 19");

   property p_space_top;
      o_space_code[2] && o_space_code != {`AEBM_FC_TOP, `AEBM_SP_RSVD};
   endproperty
   a_space_top: assert property (p_space_top) // RULE8
      else $error("space code outside 5 to 7");

   property p_hold;
      !o_address_strobe_n && !$rose(o_address_strobe_n) ##1
         !o_address_strobe_n |-> $stable(o_addr) && $stable(o_rd_wr) &&
         $stable(o_space_code) && $stable(o_xfer_size_hi) &&
         $stable(o_xfer_size_lo);
   endproperty
   a_hold: assert property (p_hold) // RULE6
      else $error("cycle outputs moved while address strobe low");

   property p_as_half;
      st_r == ST_ADDR |-> o_address_strobe_n ##1 !o_address_strobe_n;
   endproperty
   a_as_half: assert property (p_as_half) // RULE10
      else $error("address strobe not one half clock after start");

   property p_ds_read;
      $fell(o_address_strobe_n) && o_rd_wr |-> $fell(o_data_strobe_n);
   endproperty
   a_ds_read: assert property (p_ds_read) // RULE14
      else $error("read data strobe not with address strobe");

   property p_ds_write;
      $fell(o_address_strobe_n) && !o_rd_wr |->
         o_data_strobe_n && !o_data_oe ##1 o_data_strobe_n && o_data_oe
         ##1 !o_data_strobe_n;
   endproperty
   a_ds_write: assert property (p_ds_write) // RULE15 RULE13
      else $error("write strobe or data timing wrong");

   property p_oe_write;
      o_data_oe |-> !o_rd_wr && !o_address_strobe_n;
   endproperty
   a_oe_write: assert property (p_oe_write) // RULE12
      else $error("data driven outside a write cycle");

   property p_rw_start;
      $changed(o_rd_wr) |-> st_r == ST_ADDR;
   endproperty
   a_rw_start: assert property (p_rw_start) // RULE7
      else $error("direction changed away from cycle start");

   property p_stretch;
      st_r == ST_WAIT && !ack_end && !fault && !auto_vector_ack_end |=>
         st_r == ST_WAIT && !o_address_strobe_n && !o_data_strobe_n;
   endproperty
   a_stretch: assert property (p_stretch) // RULE17 RULE25 RULE21
      else $error("cycle ended without termination");

   property p_partial;
      term && !full_s && !fault && !auto_vector_ack_end |=>
         cnt_r == $past(cnt_r) - `AEBM_CNT_BYTE;
   endproperty
   a_partial: assert property (p_partial) // RULE3
      else $error("partial mode moved more than one byte");

   property p_exc;
      term && fault && halt |=> o_bus_err_exc ##1 !o_bus_err_exc;
   endproperty
   a_exc: assert property (p_exc) // RULE19
      else $error("bus error exception not raised once");

   c_split: cover property (term && !wide && cnt_r == `AEBM_CNT_LONG);
   c_wait:  cover property ((st_r == ST_WAIT) [*4] ##1 term);
   c_fault: cover property (term && fault);
   c_auto_vector_ack:  cover property (term && auto_vector_ack_end);
endmodule

// ==== test/aebm_slave.sv ====
// aebm_slave: byte memory on the far side of the external bus
// assumes: strobes active low; bench sets width, wait, fault per burst
module aebm_slave (
   input  wire logic        i_mclk,
   input  wire logic        i_as_n,
   input  wire logic        i_ds_n,
   input  wire logic        i_rd_wr,
   input  wire logic [23:0] i_addr,
   input  wire logic [2:0]  i_space,
   input  wire logic [1:0]  i_siz,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_oe,
   input  wire logic        i_wide,
   input  wire logic [3:0]  i_wait,
   input  wire logic        i_fault,
   input  wire logic        i_auto_vector_ack,
   output logic      [15:0] o_data,
   output logic             o_ack_hi_n,
   output logic             o_ack_lo_n,
   output logic             o_fault_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [3:0] cnt_r = 4'h0;
   logic       ack_r = 1'b0;
   logic [7:0] a;
   logic       end_ok;
   assign a = i_addr[7:0];
   // auto-vector ends interrupt acknowledge instead of the acks
   assign end_ok = ack_r && !(i_auto_vector_ack && i_space == 3'h7);
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   // ack held until the address strobe rises
   always @(posedge i_mclk) begin
      if (i_as_n) begin
         cnt_r <= 4'h0;
         ack_r <= 1'b0;
      end else if (cnt_r == i_wait) ack_r <= 1'b1;
      else cnt_r <= cnt_r + 4'h1;
      if (ack_r && !i_ds_n && !i_rd_wr && !i_fault && i_oe) begin
         if (!i_wide) mem[a] <= i_wdata[15:8];
         else if (a[0]) mem[a] <= i_wdata[7:0];
         else begin
            mem[a] <= i_wdata[15:8];
            if (i_siz != 2'h1) mem[a+8'h1] <= i_wdata[7:0];
         end
      end
   end
   assign o_ack_hi_n = !(end_ok && i_wide && !i_fault);
   assign o_ack_lo_n = !(end_ok && !i_wide && !i_fault);
   assign o_fault_n = !(ack_r && i_fault);
   // released lines show the inverse, never a stale value
   assign o_data = !(ack_r && i_rd_wr) ? ~{mem[a], mem[a]} :
      i_wide ? {mem[a & 8'hFE], mem[a | 8'h01]} : {mem[a], mem[a]};
endmodule

// ==== test/tb.sv ====
// tb: random bursts of transfers against the memory slave
// assumes: aebm_master top, aebm_slave model, 50 MHz clock
module tb;
   import aebm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [19:0] addr;
      logic [1:0]  siz;
      logic        wr;
      logic [2:0]  sp;
      logic [31:0] rd;
      logic        flt, av, exc;
      int          ncyc;
   } aebm_exp_s;
   logic        clk = 0, rst = 1, full = 1, vld = 0, wr = 0, iack = 0;
   logic        wide = 1, flt = 0, av = 0, hlt = 0, xs = 0, as_q = 1;
   logic        refused = 0, halt_n = 1, auto_vector_ack_n = 1;
   logic [19:0] addr = 0;
   logic [1:0]  siz = 0, sp = 0;
   logic [3:0]  wt = 0;
   logic [31:0] wdata = 0, rdata, r = 32'hFF32;
   logic [23:0] oaddr;
   logic [15:0] din, dout;
   logic [2:0]  fc;
   logic        rdy, rsp, rflt, ravec, exc, szh, szl, rw, as_n, ds_n;
   logic        ackh, ackl, flt_n, oe;
   logic [7:0]  mem_m [256];
   int          miscompares = 0, samples_checked = 0, nas = 0, cyc = 0;
   int          len;
   aebm_exp_s   q[$];
   aebm_exp_s   e;
   aebm_master dut_u (.i_mclk(clk), .i_sys_rst(rst), .i_full_mode(full),
      .i_req_valid(vld), .o_req_ready(rdy), .i_req_addr(addr),
      .i_req_write(wr), .i_req_siz(siz), .i_req_space(sp),
      .i_req_iack(iack), .i_req_wdata(wdata), .o_rsp_valid(rsp),
      .o_rsp_rdata(rdata), .o_rsp_fault(rflt), .o_rsp_auto_vector_ack(ravec),
      .o_bus_err_exc(exc), .o_addr(oaddr), .o_xfer_size_hi(szh),
      .o_xfer_size_lo(szl), .o_space_code(fc), .o_rd_wr(rw),
      .o_address_strobe_n(as_n), .o_data_strobe_n(ds_n), .i_data(din),
      .o_data(dout), .o_data_oe(oe), .i_ack_width_hi_n(ackh),
      .i_ack_width_lo_n(ackl), .i_bus_fault_n(flt_n), .i_halt_n(halt_n),
      .i_auto_vector_ack_n(auto_vector_ack_n));
   aebm_slave slv_u (.i_mclk(clk), .i_as_n(as_n), .i_ds_n(ds_n),
      .i_rd_wr(rw), .i_addr(oaddr), .i_space(fc), .i_siz({szh, szl}),
      .i_wdata(dout), .i_oe(oe), .i_wide(wide), .i_wait(wt), .i_fault(flt),
      .i_auto_vector_ack(av), .o_data(din), .o_ack_hi_n(ackh), .o_ack_lo_n(ackl),
      .o_fault_n(flt_n));
   always #10 clk = ~clk;
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // one aligned word at most per bus cycle
   function automatic int ncyc(input logic [19:0] a, input int n,
                               input logic w);
      int c, m;
      c = 0;
      while (n > 0) begin
         m = (w && !a[0] && n > 1) ? 2 : 1;
         n -= m;
         a += 20'(m);
         c++;
      end
      return c;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic push(input logic w, input logic [1:0] s);
      aebm_exp_s x;
      int n;
      @(negedge clk);
      r = nx(r);
      addr = r[19:0];
      sp = r[21:20];
      iack = !w && r[22];
      // control space under a held auto-vector would never be acked
      if (av && sp == 2'h3) sp = 2'h1;
      r = nx(r);
      wdata = r;
      wr = w;
      siz = s;
      vld = 1'b1;
      while (rdy !== 1'b1) begin
         refused = 1'b1;
         @(negedge clk);
      end
      n = (s == 2'h0) ? 4 : int'(s);
      x.addr = addr;
      x.siz = s;
      x.wr = w;
      x.sp = iack ? 3'h7 : {1'b1, sp == 2'h0 ? 2'h1 : sp};
      x.flt = flt;
      x.av = av && iack;
      x.exc = flt && hlt;
      x.rd = 0;
      for (int i = 0; i < n; i++) begin
         if (w) mem_m[8'(addr + 20'(i))] = 8'(wdata >> 8 * (n - 1 - i));
         if (!w && !flt) x.rd = {x.rd[23:0], mem_m[8'(addr + 20'(i))]};
      end
      x.ncyc = (x.flt || x.av) ? 1 : ncyc(addr, n, wide);
      q.push_back(x);
   endtask
   always @(negedge clk) begin
      if (exc === 1'b1) xs = 1'b1;
      if (as_q && !as_n && q.size() > 0) begin
         if (nas == 0) begin
            chk(oaddr, {{4{q[0].addr[19]}}, q[0].addr});
            chk({szh, szl, fc, rw, ds_n}, {q[0].siz, q[0].sp, !q[0].wr, q[0].wr});
         end
         nas++;
      end
      as_q = as_n;
      if (rsp === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk({rflt, ravec, xs}, {e.flt, e.av, e.exc});
         chk(32'(nas), 32'(e.ncyc));
         if (!e.av) chk(rdata, e.rd);
         nas = 0;
         xs = 0;
      end
   end
   always @(posedge clk) if (++cyc == 60000) begin
      miscompares++;
      final_report();
   end
   initial begin
      for (int i = 0; i < 256; i++) mem_m[i] = 8'(i) ^ 8'hA5;
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      // first burst: slow 16-bit slave, enough requests to fill the queue
      for (int p = 0; p < 40; p++) begin
         r = nx(r);
         full = p == 0 || r[0];
         wide = full && (p == 0 || r[1]);
         wt = p == 0 ? 4'h8 : r[5:2];
         flt = p > 0 && r[8:6] == 3'h0;
         av = p > 0 && r[8:6] == 3'h1;
         hlt = r[9];
         halt_n = !hlt;
         auto_vector_ack_n = !av;
         len = p == 0 ? 20 : 1 + int'(r[11:10]);
         repeat (3) @(negedge clk);
         for (int k = 0; k < len; k++) begin
            r = nx(r);
            push(!flt && r[12], r[14:13]);
         end
         @(negedge clk) vld = 1'b0;
         while (q.size() > 0) @(negedge clk);
      end
      chk(32'(refused), 32'h1);
      final_report();
   end
endmodule
